// [lmh_pkg.sv]
// Package for the list-mode serial hop controller: word layout, modes, limits.
// Assumes both ends import it.
package lmh_pkg;
  // ==========================================================
  // Hop word layout
  localparam int LMH_WORD_W = 40;
  localparam int LMH_CNT_W = 6;
  localparam int LMH_PATH_BIT = 39;
  localparam int LMH_IMM_BIT = 38;
  localparam int LMH_CMD_HI = 37;
  localparam int LMH_CMD_LO = 33;
  localparam int LMH_LIST_BIT = 32;
  localparam int LMH_IDX_W = 32;
  // ==========================================================
  // List store and level limits
  localparam int LMH_ADDR_W = 6;
  localparam int LMH_DEPTH = 64;
  localparam int LMH_FREQ_W = 32;
  localparam int LMH_LVL_W = 16;
  localparam logic [LMH_LVL_W-1:0] LMH_NORM_MIN = 16'h8000;
  localparam logic [LMH_LVL_W-1:0] LMH_NORM_MAX = 16'h7FFF;
  localparam logic [LMH_LVL_W-1:0] LMH_HP_MIN = 16'h0800;
  localparam logic [LMH_LVL_W-1:0] LMH_HP_MAX = 16'h7FFF;
  localparam logic [LMH_LVL_W-1:0] LMH_NORM_TOP = 16'h07FF;
  // Dwell counter width and settings computation time per entry
  localparam int LMH_DWELL_W = 16;
  localparam logic [LMH_DWELL_W-1:0] LMH_LEARN_CYC = 16'h0004;
  // Host bit clock divider: bit period in clk_sys cycles
  localparam logic [3:0] LMH_HALF_DIV = 4'h4;
  // ==========================================================
  // List operating modes
  typedef enum logic [2:0] {
    LMH_M_AUTO, LMH_M_SINGLE, LMH_M_STEP, LMH_M_EXT_SINGLE, LMH_M_EXT_STEP,
    LMH_M_HOP, LMH_M_HOP_DIRECT
  } lmh_mode_t;
endpackage

// [lmh_if.sv]
// Interface carrying the three-wire hop bus between controller and device.
// Assumes the controller drives all three lines.
`timescale 1ns/100ps
interface lmh_if;
  logic hop_clk; // Bit clock from the controller
  logic hop_strobe; // High with the last bit of a word
  logic hop_data; // Serial data, most significant bit first
  modport ctrl (output hop_clk, output hop_strobe, output hop_data);
  modport dev (input hop_clk, input hop_strobe, input hop_data);
endinterface

// [lmh_ctrl.sv]
// Controller end: shifts one 40-bit hop word out per request.
// Assumes the device samples on the rising bit clock edge.
`timescale 1ns/100ps
module lmh_ctrl
  import lmh_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic send, // Pulse: send a word
  input wire logic imm_n, // Zero applies at once, one waits for trigger
  input wire logic [LMH_IDX_W-1:0] index, // List index to send
  output logic busy, // Word in flight
  lmh_if.ctrl bus // Serial hop bus
);
  typedef struct packed {
    logic [LMH_WORD_W-1:0] sh;
    logic [LMH_CNT_W-1:0] left;
    logic [3:0] div;
    logic clk;
    logic stb;
    logic dat;
    logic busy;
  } lmh_cst_t;
  lmh_cst_t s;
  lmh_cst_t next_s;
  logic [3:0] nd;
  // ==========================================================
  // Word build and bit timing: a bit period is LMH_HALF_DIV cycles; data changes
  // as the clock falls and stands over the whole high half, so the rise is safe
  always_comb begin
    next_s = s;
    nd = (s.div == LMH_HALF_DIV - 4'h1) ? 4'h0 : s.div + 4'h1;
    if (!s.busy) begin
      next_s.clk = 1'b0;
      next_s.stb = 1'b0;
      if (send) begin
        // Path zero, list function set, reserved zero
        next_s.sh = {1'b0, imm_n, 5'h00, 1'b1, index};
        next_s.left = 6'h28;
        next_s.busy = 1'b1;
        next_s.div = LMH_HALF_DIV - 4'h1; // First bit goes out on the next edge
      end
    end else begin
      next_s.div = nd;
      next_s.clk = (nd >= (LMH_HALF_DIV >> 1));
      if (s.div == LMH_HALF_DIV - 4'h1) begin
        if (s.left == 6'h00) begin
          // Last bit done: clock parks low, strobe drops
          next_s.busy = 1'b0;
          next_s.stb = 1'b0;
          next_s.clk = 1'b0;
          next_s.div = 4'h0;
        end else begin
          next_s.dat = s.sh[LMH_WORD_W-1];
          next_s.sh = {s.sh[LMH_WORD_W-2:0], 1'b0};
          next_s.stb = (s.left == 6'h01);
          next_s.left = s.left - 6'h01;
        end
      end
    end
  end
  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign bus.hop_clk = s.clk;
  assign bus.hop_strobe = s.stb;
  assign bus.hop_data = s.dat;
  assign busy = s.busy;
endmodule

// [lmh_dev.sv]
// Device end: receives hop words on the link clock, runs list mode on clk_sys.
// Assumes the bit clock runs only during words and trigger is asynchronous.
`timescale 1ns/100ps
module lmh_dev
  import lmh_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Asynchronous reset, active high
  lmh_if.dev bus, // Serial hop bus
  input wire logic instrument_trigger_input, // Asynchronous trigger pin
  input wire logic trig_slope_neg, // One selects falling edge
  input wire logic list_on_req, // Pulse: enable list mode
  input wire logic sweep_on_req, // Pulse: enable sweep
  input wire logic off_req, // Pulse: disable both
  input wire logic [2:0] mode, // List mode, lmh_mode_t
  input wire logic exec_req, // Pulse: start single / step advance
  input wire logic learn_req, // Pulse: force settings learning
  input wire logic high_power, // Attenuator high power mode
  input wire logic [LMH_ADDR_W:0] list_len, // Valid entries
  input wire logic [LMH_DWELL_W-1:0] dwell, // Dwell cycles per step
  input wire logic wr_en, // Write a list entry
  input wire logic [LMH_ADDR_W-1:0] wr_addr, // Entry address
  input wire logic [LMH_FREQ_W-1:0] wr_freq, // Entry frequency
  input wire logic [LMH_LVL_W-1:0] wr_lvl, // Entry level
  output logic list_active, // List mode on
  output logic sweep_active, // Sweep on
  output logic learning, // Computing hardware settings
  output logic apply, // Pulse: new setting
  output logic [LMH_FREQ_W-1:0] freq_out, // Applied frequency
  output logic [LMH_LVL_W-1:0] lvl_out, // Applied level
  output logic [LMH_IDX_W-1:0] cur_index, // Current index
  output logic level_err, // Sticky: level clamped
  output logic index_err, // Sticky: index out of list
  output logic dwell_dev // Sticky: first pass over dwell
);
  // ==========================================================
  // Link domain: shift on every rising bit clock edge, latch on strobe
  typedef struct packed {
    logic [LMH_WORD_W-1:0] sh;
    logic [LMH_WORD_W-1:0] word;
    logic tog;
  } lmh_lst_t;
  lmh_lst_t l;
  lmh_lst_t next_l;
  always_comb begin
    next_l = l;
    next_l.sh = {l.sh[LMH_WORD_W-2:0], bus.hop_data};
    if (bus.hop_strobe) begin
      next_l.word = {l.sh[LMH_WORD_W-2:0], bus.hop_data};
      next_l.tog = ~l.tog;
    end
  end
  always_ff @(posedge bus.hop_clk or posedge rst) begin
    if (rst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end
  // ==========================================================
  // List store
  logic [LMH_FREQ_W-1:0] freq_mem [LMH_DEPTH];
  logic [LMH_LVL_W-1:0] lvl_mem [LMH_DEPTH];
  logic learned_mem [LMH_DEPTH];
  // ==========================================================
  // System domain state
  typedef enum logic [1:0] {LMH_S_IDLE, LMH_S_LEARN, LMH_S_RUN} lmh_st_t;
  typedef struct packed {
    logic [2:0] tsync;
    logic [1:0] trig_sync;
    logic trig_last;
    lmh_st_t st;
    logic list_on;
    logic sweep_on;
    logic learned;
    logic first_pass;
    logic pend;
    logic [LMH_IDX_W-1:0] pidx;
    logic [LMH_IDX_W-1:0] idx;
    logic [LMH_DWELL_W-1:0] cnt;
    logic [LMH_ADDR_W:0] lidx;
    logic go;
    logic apply;
    logic [LMH_FREQ_W-1:0] freq;
    logic [LMH_LVL_W-1:0] lvl;
    logic lerr;
    logic ierr;
    logic derr;
  } lmh_sst_t;
  lmh_sst_t s;
  lmh_sst_t next_s;
  logic [LMH_WORD_W-1:0] rx_word;
  logic trig_lvl;
  logic trig_ev;
  logic word_ev;
  lmh_mode_t m;
  logic hop_mode;
  logic [LMH_ADDR_W-1:0] ea;
  logic [LMH_LVL_W-1:0] raw_lvl;
  logic last_step;
  // Clamp a level to the selected attenuator range
  function automatic logic [LMH_LVL_W-1:0] lmh_clamp(input logic [LMH_LVL_W-1:0] v,
                                                     input logic hp);
    logic [LMH_LVL_W-1:0] r;
    r = v;
    if (hp) begin
      if ($signed(v) < $signed(LMH_HP_MIN)) r = LMH_HP_MIN;
    end else begin
      if ($signed(v) > $signed(LMH_NORM_TOP)) r = LMH_NORM_TOP;
    end
    return r;
  endfunction
  assign m = lmh_mode_t'(mode);
  assign hop_mode = (m == LMH_M_HOP) || (m == LMH_M_HOP_DIRECT);
  // Word crosses as a toggle; word is stable for many link edges after toggling
  assign word_ev = s.tsync[2] ^ s.tsync[1];
  assign rx_word = l.word;
  assign trig_lvl = s.trig_sync[1] ^ trig_slope_neg;
  assign trig_ev = trig_lvl && !s.trig_last;
  assign ea = s.idx[LMH_ADDR_W-1:0];
  assign raw_lvl = lvl_mem[ea];
  assign last_step = ({1'b0, ea} + 7'h01) >= list_len;
  // ==========================================================
  // Next state of the list engine
  always_comb begin
    next_s = s;
    next_s.tsync = {s.tsync[1:0], l.tog};
    next_s.trig_sync = {s.trig_sync[0], instrument_trigger_input};
    next_s.trig_last = trig_lvl;
    next_s.go = 1'b0;
    next_s.apply = 1'b0;
    if (list_on_req) begin
      next_s.list_on = 1'b1;
      next_s.sweep_on = 1'b0;
      next_s.idx = '0;
      next_s.first_pass = 1'b1;
      next_s.st = s.learned ? LMH_S_RUN : LMH_S_LEARN;
      next_s.lidx = '0;
      next_s.cnt = '0;
      next_s.go = s.learned && !hop_mode && m == LMH_M_AUTO;
    end else if (sweep_on_req) begin
      next_s.sweep_on = 1'b1;
      next_s.list_on = 1'b0;
      next_s.st = LMH_S_IDLE;
    end else if (off_req) begin
      next_s.list_on = 1'b0;
      next_s.sweep_on = 1'b0;
      next_s.st = LMH_S_IDLE;
    end else if (learn_req && s.list_on) begin
      next_s.st = LMH_S_LEARN;
      next_s.lidx = '0;
      next_s.cnt = '0;
    end else if (s.st == LMH_S_LEARN) begin
      // Compute settings for every entry before first run
      if (s.cnt == LMH_LEARN_CYC) begin
        next_s.cnt = '0;
        next_s.lidx = s.lidx + 7'h01;
        if (s.lidx + 7'h01 >= list_len) begin
          next_s.learned = 1'b1;
          next_s.st = LMH_S_RUN;
          next_s.go = (m == LMH_M_AUTO);
        end
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end else if (s.st == LMH_S_RUN) begin
      case (m)
        LMH_M_HOP, LMH_M_HOP_DIRECT: begin
          if (word_ev) begin
            if ({1'b0, rx_word[LMH_IDX_W-1:0]} >= {26'h0, list_len}) begin
              next_s.ierr = 1'b1;
            end else if (!rx_word[LMH_IMM_BIT]) begin
              next_s.idx = rx_word[LMH_IDX_W-1:0];
              next_s.go = 1'b1;
            end else begin
              next_s.pidx = rx_word[LMH_IDX_W-1:0];
              next_s.pend = 1'b1;
            end
          end else if (trig_ev && s.pend) begin
            next_s.idx = s.pidx;
            next_s.pend = 1'b0;
            next_s.go = 1'b1;
          end
        end
        LMH_M_STEP, LMH_M_EXT_STEP: begin
          if ((m == LMH_M_STEP) ? exec_req : trig_ev) begin
            next_s.idx = last_step ? '0 : s.idx + 32'h1;
            next_s.go = 1'b1;
          end
        end
        LMH_M_AUTO, LMH_M_SINGLE, LMH_M_EXT_SINGLE: begin
          if (s.cnt != '0) begin
            next_s.cnt = s.cnt - 16'h0001;
            if (s.cnt == 16'h0001) begin
              if (last_step) begin
                next_s.first_pass = 1'b0;
                next_s.idx = '0;
                next_s.go = (m == LMH_M_AUTO);
              end else begin
                next_s.idx = s.idx + 32'h1;
                next_s.go = 1'b1;
              end
            end
          end else if ((m == LMH_M_SINGLE && exec_req) ||
                       (m == LMH_M_EXT_SINGLE && trig_ev)) begin
            next_s.idx = '0;
            next_s.go = 1'b1;
          end
        end
        default: begin
          next_s.go = 1'b0;
        end
      endcase
    end
    // Apply the entry of the current index
    if (s.go && s.list_on) begin
      next_s.freq = freq_mem[ea];
      next_s.lvl = lmh_clamp(raw_lvl, high_power);
      next_s.apply = 1'b1;
      if (lmh_clamp(raw_lvl, high_power) != raw_lvl) begin
        next_s.lerr = 1'b1;
      end
      if (!hop_mode && m != LMH_M_STEP && m != LMH_M_EXT_STEP) begin
        // First pass pays the settings time once, flagged when it exceeds dwell
        if (s.first_pass && !learned_mem[ea] && dwell < LMH_LEARN_CYC) begin
          next_s.cnt = LMH_LEARN_CYC;
          next_s.derr = 1'b1;
        end else begin
          next_s.cnt = (dwell == '0) ? 16'h0001 : dwell;
        end
      end
    end
  end
  // ==========================================================
  // State registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // List store writes; learned marks set as entries are used, cleared when written unless an entry is used in the same cycle
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      freq_mem[wr_addr] <= wr_freq;
      lvl_mem[wr_addr] <= wr_lvl;
    end
    if (s.go) begin
      learned_mem[ea] <= 1'b1;
    end else if (wr_en) begin
      learned_mem[wr_addr] <= 1'b0;
    end
  end
  assign list_active = s.list_on;
  assign sweep_active = s.sweep_on;
  assign learning = (s.st == LMH_S_LEARN);
  assign apply = s.apply;
  assign freq_out = s.freq;
  assign lvl_out = s.lvl;
  assign cur_index = s.idx;
  assign level_err = s.lerr;
  assign index_err = s.ierr;
  assign dwell_dev = s.derr;
endmodule

// [lmh_chk.sv]
// Checker for the three-wire hop bus between the two ends.
// Assumes the controller end drives the bus from clk_sys registers.
`timescale 1ns/100ps
module lmh_chk (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic hop_clk, // Bit clock
  input wire logic hop_strobe, // Last bit marker
  input wire logic hop_data // Serial data
);
  logic clk_q;
  logic rise;
  logic [5:0] cnt;
  // ==========================================================
  // Bit position of the bit now on the wire, counted on bit clock rises
  assign rise = hop_clk && !clk_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_q <= 1'b0;
      cnt <= 6'h00;
    end else begin
      clk_q <= hop_clk;
      if (rise) begin
        cnt <= hop_strobe ? 6'h00 : cnt + 6'h01; // Strobe restarts framing
      end
    end
  end
  // ==========================================================
  // Wire assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence bit_at(int n);
    rise && cnt == n;
  endsequence
  sequence word_end;
    rise && hop_strobe;
  endsequence
  strobe_last_a: assert property (word_end |-> cnt == 6'h27)
    else $error("strobe not on the fortieth bit");
  early_strobe_a: assert property (rise && cnt != 6'h27 |-> !hop_strobe)
    else $error("strobe before the last bit");
  path_bit_a: assert property (bit_at(0) |-> !hop_data)
    else $error("path bit not zero");
  list_bit_a: assert property (bit_at(7) |-> hop_data)
    else $error("list function bit not one");
  reserved_zero_a: assert property (rise && cnt inside {[2:6]} |-> !hop_data)
    else $error("reserved function bit not zero");
  data_stable_a: assert property (hop_clk && clk_q |-> $stable(hop_data) && $stable(hop_strobe))
    else $error("data moved while bit clock high");
  strobe_clears_a: assert property (word_end |-> ##[1:16] !hop_strobe)
    else $error("strobe held after word");
  clk_idles_a: assert property (word_end |-> ##[1:12] !hop_clk)
    else $error("bit clock not back low after word");
endmodule

// [testbench.sv]
// Testbench joining the controller end and the device end over the hop bus.
// Assumes both ends share clk_sys and rst; the controller makes the bit clock.
`timescale 1ns/100ps
module testbench;
  import lmh_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, send = 1'b0, imm_n = 1'b0, busy;
  logic [31:0] index = 32'h0;
  logic instrument_trigger_input = 1'b0, trig_slope_neg = 1'b0, high_power = 1'b0;
  logic list_on_req = 1'b0, sweep_on_req = 1'b0, off_req = 1'b0;
  logic exec_req = 1'b0, learn_req = 1'b0, wr_en = 1'b0;
  logic [2:0] mode = LMH_M_HOP;
  logic [6:0] list_len = 7'h10;
  logic [15:0] dwell = 16'h0008, wr_lvl = 16'h0;
  logic [5:0] wr_addr = 6'h0;
  logic [31:0] wr_freq = 32'h0, cur_index, freq_out;
  logic [15:0] lvl_out;
  logic list_active, sweep_active, learning, apply, level_err, index_err, dwell_dev;
  logic [39:0] wire_sr = 40'h0, wire_word = 40'h0;
  logic got;
  int errors = 0;
  int tests_run = 0;
  lmh_if hop_bus();
  lmh_ctrl i_lmh_ctrl (.clk_sys, .rst, .send, .imm_n, .index, .busy, .bus(hop_bus));
  lmh_dev i_lmh_dev (.clk_sys, .rst, .bus(hop_bus), .instrument_trigger_input,
    .trig_slope_neg, .list_on_req, .sweep_on_req, .off_req, .mode, .exec_req,
    .learn_req, .high_power, .list_len, .dwell, .wr_en, .wr_addr, .wr_freq, .wr_lvl,
    .list_active, .sweep_active, .learning, .apply, .freq_out, .lvl_out, .cur_index,
    .level_err, .index_err, .dwell_dev);
  lmh_chk i_lmh_chk (.clk_sys, .rst, .hop_clk(hop_bus.hop_clk),
    .hop_strobe(hop_bus.hop_strobe), .hop_data(hop_bus.hop_data));
  // ==========================================================
  // Clock, and a copy of each word as it appears on the wire
  always #5 clk_sys = ~clk_sys;
  always @(posedge hop_bus.hop_clk) begin
    wire_sr <= {wire_sr[38:0], hop_bus.hop_data};
    if (hop_bus.hop_strobe) wire_word <= {wire_sr[38:0], hop_bus.hop_data};
  end
  // ==========================================================
  // Compare and bus tasks
  task automatic check(input logic [39:0] g, input logic [39:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic check_bit(input logic g, input logic e);
    check({39'h0, g}, {39'h0, e});
  endtask
  task automatic ctl(input logic l, input logic s, input logic o);
    @(posedge clk_sys);
    {list_on_req, sweep_on_req, off_req} <= {l, s, o};
    @(posedge clk_sys);
    {list_on_req, sweep_on_req, off_req} <= 3'h0;
  endtask
  // Launch only; the word is still in flight on return
  task automatic send_word(input logic im, input logic [31:0] idx);
    @(posedge clk_sys);
    {imm_n, index, send} <= {im, idx, 1'b1};
    @(posedge clk_sys);
    send <= 1'b0;
  endtask
  task automatic wait_apply(input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk_sys); #1;
      got = (apply === 1'b1);
    end
  endtask
  // Busy low plus the spacing that back-to-back words need
  task automatic wait_idle();
    #1;
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk_sys);
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic set_trig(input logic v);
    @(posedge clk_sys);
    instrument_trigger_input <= v;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_excl();
    ctl(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys); #1;
    check_bit(learning, 1'b1);
    for (int i = 0; i < 400 && learning !== 1'b0; i++) @(posedge clk_sys);
    check({38'h0, list_active, sweep_active}, 40'h2);
    ctl(1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge clk_sys); #1;
    check({38'h0, list_active, sweep_active}, 40'h1);
    ctl(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys); #1;
    check({37'h0, list_active, sweep_active, learning}, 40'h4);
    $display("test exclusion done");
  endtask
  task automatic t_direct();
    send_word(1'b0, 32'h5);
    wait_apply(500);
    check_bit(got, 1'b1);
    check({8'h0, cur_index}, 40'h5);
    check({8'h0, freq_out}, 40'h0100_0005);
    check({24'h0, lvl_out}, 40'h15);
    check({38'h0, index_err, level_err}, 40'h0);
    wait_idle();
    check(wire_word, 40'h01_0000_0005);
    $display("test direct hop done");
  endtask
  task automatic t_trig();
    send_word(1'b1, 32'h9);
    wait_apply(400);
    check_bit(got, 1'b0);
    wait_idle();
    check(wire_word, 40'h41_0000_0009);
    set_trig(1'b1);
    wait_apply(20);
    check_bit(got, 1'b1);
    check({8'h0, cur_index}, 40'h9);
    @(posedge clk_sys);
    trig_slope_neg <= 1'b1;
    set_trig(1'b0); // Falling edge with no pending word
    wait_apply(20);
    check_bit(got, 1'b0);
    send_word(1'b1, 32'h3);
    wait_idle();
    set_trig(1'b1);
    wait_apply(20);
    check_bit(got, 1'b0);
    set_trig(1'b0);
    wait_apply(20);
    check_bit(got, 1'b1);
    check({8'h0, cur_index}, 40'h3);
    $display("test trigger hop done");
  endtask
  task automatic t_errs();
    send_word(1'b0, 32'h14);
    wait_apply(400);
    check({38'h0, got, index_err}, 40'h1);
    wait_idle();
    send_word(1'b0, 32'h2);
    wait_apply(400);
    check({23'h0, level_err, lvl_out}, 40'h1_07FF);
    wait_idle();
    @(posedge clk_sys);
    high_power <= 1'b1;
    send_word(1'b0, 32'h4);
    wait_apply(400);
    check({24'h0, lvl_out}, 40'h0800);
    wait_idle();
    $display("test level and index errors done");
  endtask
  task automatic t_walk();
    ctl(1'b0, 1'b0, 1'b1);
    @(posedge clk_sys);
    mode <= LMH_M_AUTO;
    ctl(1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      wait_apply(200);
      check({7'h0, got, cur_index}, 40'h1_0000_0000 + k);
    end
    check_bit(dwell_dev, 1'b0);
    $display("test sequential walk done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Main sequence: reset, fill the list, run the scenarios
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      @(posedge clk_sys);
      wr_en <= 1'b1;
      wr_addr <= 6'(a);
      wr_freq <= 32'h0100_0000 | 32'(a);
      wr_lvl <= (a == 2) ? 16'h1000 : (a == 4) ? 16'h0100 : 16'h0010 + 16'(a);
    end
    @(posedge clk_sys);
    wr_en <= 1'b0;
    t_excl();
    t_direct();
    t_trig();
    t_errs();
    t_walk();
    wrap_up();
  end
  // Watchdog well beyond the roughly 2000 cycles the scenarios need
  initial begin
    #500000;
    errors++;
    wrap_up();
  end
endmodule
